// ==== pkg/pll_status_holdover_pkg.sv ====
// Purpose: shared constants and carriers for the loop control and readback bank
// Assumes: byte-wide control port with printed register addresses
// Notes: only the bits owned by this bank are stored; other bits read zero
package pll_status_holdover_pkg;

    // register addresses as printed
    localparam logic [9:0] ADDR_HOLDOVER_CTRL = 10'h01D;
    localparam logic [9:0] ADDR_ZERO_DELAY = 10'h01E;
    localparam logic [9:0] ADDR_READBACK = 10'h01F;

    // field positions in the holdover control register
    localparam int BIT_HOLDOVER_EN = 0;
    localparam int BIT_EXT_HOLDOVER = 1;
    localparam int BIT_STATUS_DISABLE = 4;

    // field position in the zero delay register
    localparam int BIT_ZERO_DELAY = 1;

    // reset values
    localparam logic RST_HOLDOVER_EN = 1'h0;
    localparam logic RST_EXT_HOLDOVER = 1'h0;
    localparam logic RST_STATUS_DISABLE = 1'h0;
    localparam logic RST_ZERO_DELAY = 1'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // readback layout, bit 5 down to bit 0
    typedef struct packed {
        logic holdover_active;
        logic secondary_selected;
        logic clk_above;
        logic secondary_above;
        logic primary_above;
        logic digital_lock;
    } pll_status_t;

    localparam pll_status_t RST_STATUS = '0;

    // one access from the serial control port
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } reg_req_t;

endpackage

// ==== verilog/status_snapshot.sv ====
// Purpose: holds the readback status word presented to software
// Assumes: monitor inputs are synchronous to sys_clk
// Notes: has no write path at all, so software cannot disturb it
module status_snapshot (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic refresh_en,
    input pll_status_holdover_pkg::pll_status_t sample_in,
    output pll_status_holdover_pkg::pll_status_t status_q
);
    import pll_status_holdover_pkg::*;

    // sample every cycle while refresh is on, freeze otherwise
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_q <= RST_STATUS;
        end else if (refresh_en) begin
            status_q <= sample_in;
        end
    end

endmodule // status_snapshot

// ==== verilog/pll_status_holdover_regs.sv ====
// Purpose: loop holdover and zero delay controls plus the loop readback register
// Assumes: requests arrive one per cycle from the serial control port, synchronous
// Notes: read data appear one cycle after the read strobe with reg_rvalid
//
// Operation
// - holdover enable bit turns on holdover
// - zero delay bit one enables zero delay
// - status bit five shows holdover state itself
// - status bit four shows selected reference
// - status bit three shows clock above threshold
// - status bit two shows secondary above threshold
// - status bit one shows primary above threshold
// - status bit zero shows digital lock
// - status disable bit freezes readback updates
// - external holdover bit hands entry to pin
module pll_status_holdover_regs (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input pll_status_holdover_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input pll_status_holdover_pkg::pll_status_t monitor_status,
    input wire logic hold_pin,
    input wire logic auto_holdover_request,
    output logic holdover_enable,
    output logic external_holdover_enable,
    output logic zero_delay_enable,
    output logic holdover_entry_request
);
    import pll_status_holdover_pkg::*;

    logic status_disable;
    logic hit_holdover_ctrl;
    logic hit_zero_delay;
    logic hit_readback;
    logic [7:0] next_rdata;
    pll_status_t status_q;

    // address decode, shared by reads and writes
    assign hit_holdover_ctrl = (reg_req.addr == ADDR_HOLDOVER_CTRL);
    assign hit_zero_delay = (reg_req.addr == ADDR_ZERO_DELAY);
    assign hit_readback = (reg_req.addr == ADDR_READBACK);

    // holdover control register: enable, external mode, status disable
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            holdover_enable <= RST_HOLDOVER_EN;
            external_holdover_enable <= RST_EXT_HOLDOVER;
            status_disable <= RST_STATUS_DISABLE;
        end else if (reg_req.we && hit_holdover_ctrl) begin
            holdover_enable <= reg_req.wdata[BIT_HOLDOVER_EN];
            external_holdover_enable <= reg_req.wdata[BIT_EXT_HOLDOVER];
            status_disable <= reg_req.wdata[BIT_STATUS_DISABLE];
        end
    end

    // zero delay register, only bit one is live
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            zero_delay_enable <= RST_ZERO_DELAY;
        end else if (reg_req.we && hit_zero_delay) begin
            zero_delay_enable <= reg_req.wdata[BIT_ZERO_DELAY];
        end
    end

    // holdover entry source: pin in external mode, automatic circuit otherwise
    // registered so the output is glitch free, costs one cycle of latency
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            holdover_entry_request <= 1'h0;
        end else if (external_holdover_enable) begin
            holdover_entry_request <= hold_pin;
        end else begin
            holdover_entry_request <= auto_holdover_request;
        end
    end

    // readback word; no write path reaches it
    status_snapshot u_status (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .refresh_en(!status_disable),
        .sample_in(monitor_status),
        .status_q(status_q)
    );

    // read mux; unmapped addresses answer zero, unused bits read zero
    always_comb begin
        next_rdata = UNMAPPED_RDATA;
        if (hit_holdover_ctrl) begin
            next_rdata[BIT_HOLDOVER_EN] = holdover_enable;
            next_rdata[BIT_EXT_HOLDOVER] = external_holdover_enable;
            next_rdata[BIT_STATUS_DISABLE] = status_disable;
        end else if (hit_zero_delay) begin
            next_rdata[BIT_ZERO_DELAY] = zero_delay_enable;
        end else if (hit_readback) begin
            next_rdata = {2'h0, status_q};
        end
    end

    // read data register, held until the next read
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= RST_RDATA;
        end else if (reg_req.re) begin
            reg_rdata <= next_rdata;
        end
    end

    // read valid is the read strobe delayed by one cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rvalid <= 1'h0;
        end else begin
            reg_rvalid <= reg_req.re;
        end
    end

    // checks on the bank's own behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence ctrl_write_s;
        reg_req.we && hit_holdover_ctrl;
    endsequence

    sequence status_read_s;
        reg_req.re && hit_readback;
    endsequence

    sequence refresh_run_s;
        !status_disable ##1 !status_disable;
    endsequence

    hold_enable_a: assert property (
        ctrl_write_s |=> holdover_enable == $past(reg_req.wdata[BIT_HOLDOVER_EN]))
        else $error("holdover enable did not follow write");

    zero_delay_a: assert property (
        (reg_req.we && hit_zero_delay)
        |=> zero_delay_enable == $past(reg_req.wdata[BIT_ZERO_DELAY]))
        else $error("zero delay enable did not follow write");

    hold_state_a: assert property (
        refresh_run_s |-> status_q.holdover_active == $past(monitor_status.holdover_active))
        else $error("holdover active bit not tracking state");

    status_read_a: assert property (
        status_read_s ##1 1'b1
        |-> reg_rvalid && reg_rdata == {2'h0, $past(status_q)})
        else $error("readback data mismatch");

    // refresh must already be on the cycle before the read, else the snapshot is stale
    lock_read_a: assert property (
        !status_disable ##1 status_read_s ##1 1'b1
        |-> reg_rdata[0] == $past(monitor_status.digital_lock, 2))
        else $error("lock bit readback mismatch");

    monitor_track_a: assert property (
        refresh_run_s |-> status_q == $past(monitor_status))
        else $error("monitor bits not tracking");

    status_freeze_a: assert property (
        status_disable |=> $stable(status_q))
        else $error("status changed while refresh disabled");

    ext_hold_a: assert property (
        external_holdover_enable |=> holdover_entry_request == $past(hold_pin))
        else $error("holdover entry not following pin");

    auto_hold_a: assert property (
        !external_holdover_enable
        |=> holdover_entry_request == $past(auto_holdover_request))
        else $error("holdover entry not following automatic circuit");

    // frozen case is covered by status_freeze_a; here a write must not beat the monitors
    ro_write_a: assert property (
        (reg_req.we && hit_readback && !status_disable)
        |=> status_q == $past(monitor_status))
        else $error("write disturbed readback register");

    rvalid_pulse_a: assert property (
        reg_rvalid |-> $past(reg_req.re))
        else $error("read valid without read strobe");

    // per-field checks; a stuck or swapped bit could hide behind a word compare
    ref_select_a: assert property (
        refresh_run_s
        |-> status_q.secondary_selected == $past(monitor_status.secondary_selected))
        else $error("reference select bit not tracking");

    clk_above_a: assert property (
        refresh_run_s
        |-> status_q.clk_above == $past(monitor_status.clk_above))
        else $error("clock threshold bit not tracking");

    secondary_above_a: assert property (
        refresh_run_s
        |-> status_q.secondary_above == $past(monitor_status.secondary_above))
        else $error("secondary threshold bit not tracking");

    primary_above_a: assert property (
        refresh_run_s
        |-> status_q.primary_above == $past(monitor_status.primary_above))
        else $error("primary threshold bit not tracking");

    lock_track_a: assert property (
        refresh_run_s
        |-> status_q.digital_lock == $past(monitor_status.digital_lock))
        else $error("lock bit not tracking");

    // control readback, so software sees what it wrote
    ctrl_read_a: assert property (
        (reg_req.re && hit_holdover_ctrl)
        |=> reg_rdata[BIT_HOLDOVER_EN] == $past(holdover_enable))
        else $error("holdover enable readback mismatch");

    ext_read_a: assert property (
        (reg_req.re && hit_holdover_ctrl)
        |=> reg_rdata[BIT_EXT_HOLDOVER] == $past(external_holdover_enable))
        else $error("external holdover readback mismatch");

    disable_read_a: assert property (
        (reg_req.re && hit_holdover_ctrl)
        |=> reg_rdata[BIT_STATUS_DISABLE] == $past(status_disable))
        else $error("status disable readback mismatch");

    zero_read_a: assert property (
        (reg_req.re && hit_zero_delay)
        |=> reg_rdata[BIT_ZERO_DELAY] == $past(zero_delay_enable))
        else $error("zero delay readback mismatch");

    // read data must stand until the next read strobe
    rdata_hold_a: assert property (
        !reg_req.re |=> $stable(reg_rdata))
        else $error("read data changed without a read");

endmodule // pll_status_holdover_regs

// ==== tb/test_pll_status_holdover_regs.sv ====
// Purpose: self-checking bench for the loop control and readback bank
// Assumes: one-cycle read strobe, answer exactly one cycle later
// Notes: inputs change on the falling edge, so no race with the sampling edge
module test_pll_status_holdover_regs;
    timeunit 1ns;
    timeprecision 100ps;
    import pll_status_holdover_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_t reg_req = '0;
    pll_status_t monitor_status = '0;
    logic hold_pin = 1'b0;
    logic auto_holdover_request = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid, holdover_enable, external_holdover_enable;
    logic zero_delay_enable, holdover_entry_request;
    logic [7:0] d;
    int bad_count = 0;
    int cmp_count = 0;
    pll_status_holdover_regs DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .monitor_status(monitor_status),
        .hold_pin(hold_pin), .auto_holdover_request(auto_holdover_request),
        .holdover_enable(holdover_enable), .external_holdover_enable(external_holdover_enable),
        .zero_delay_enable(zero_delay_enable), .holdover_entry_request(holdover_entry_request));
    // 8 ns period
    always #4 sys_clk = ~sys_clk;
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_byte({7'h00, got}, {7'h00, exp}, what);
    endtask
    // strobe held one full cycle, dropped at the next falling edge
    task automatic reg_write(input logic [9:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        reg_req.addr = a;
        reg_req.wdata = v;
        reg_req.we = 1'b1;
        @(negedge sys_clk);
        reg_req.we = 1'b0;
    endtask
    // answer is fixed at one cycle, so no polling loop is needed
    task automatic reg_read(input logic [9:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        reg_req.addr = a;
        reg_req.re = 1'b1;
        @(negedge sys_clk);
        reg_req.re = 1'b0;
        chk_bit(reg_rvalid, 1'b1, "read valid");
        v = reg_rdata;
    endtask
    task automatic test_reset;
        chk_bit(zero_delay_enable, 1'b0, "zero delay default");
        chk_bit(holdover_enable, 1'b0, "holdover default");
        reg_read(ADDR_HOLDOVER_CTRL, d);
        chk_byte(d, 8'h00, "holdover ctrl reset");
        reg_read(ADDR_ZERO_DELAY, d);
        chk_byte(d, 8'h00, "zero delay reset");
    endtask
    task automatic test_controls;
        reg_write(ADDR_HOLDOVER_CTRL, 8'h03);
        chk_bit(holdover_enable, 1'b1, "holdover on");
        chk_bit(external_holdover_enable, 1'b1, "ext holdover on");
        reg_read(ADDR_HOLDOVER_CTRL, d);
        chk_byte(d, 8'h03, "holdover ctrl readback");
        reg_write(ADDR_ZERO_DELAY, 8'hFF);
        chk_bit(zero_delay_enable, 1'b1, "zero delay on");
        reg_read(ADDR_ZERO_DELAY, d);
        chk_byte(d, 8'h02, "zero delay readback");
        reg_write(ADDR_ZERO_DELAY, 8'h00);
        chk_bit(zero_delay_enable, 1'b0, "zero delay off");
        reg_write(ADDR_HOLDOVER_CTRL, 8'h00);
        chk_bit(holdover_enable, 1'b0, "holdover off");
    endtask
    // walk a single one across the six status bits
    task automatic test_status;
        logic [5:0] v;
        for (int i = 0; i < 6; i++) begin
            v = 6'h01 << i;
            monitor_status = v;
            reg_read(ADDR_READBACK, d);
            chk_byte(d, {2'h0, v}, "status bit");
        end
    endtask
    task automatic test_freeze;
        monitor_status = 6'h2A;
        reg_write(ADDR_HOLDOVER_CTRL, 8'h10);
        monitor_status = 6'h15;
        reg_read(ADDR_HOLDOVER_CTRL, d);
        chk_byte(d, 8'h10, "status disable readback");
        reg_read(ADDR_READBACK, d);
        chk_byte(d, 8'h2A, "frozen status");
        reg_write(ADDR_READBACK, 8'hFF);
        reg_read(ADDR_READBACK, d);
        chk_byte(d, 8'h2A, "status after write");
        reg_write(ADDR_HOLDOVER_CTRL, 8'h00);
        @(negedge sys_clk);
        reg_read(ADDR_READBACK, d);
        chk_byte(d, 8'h15, "live status again");
        reg_write(ADDR_READBACK, 8'hC0);
        reg_read(ADDR_READBACK, d);
        chk_byte(d, 8'h15, "live status after write");
        reg_read(10'h100, d);
        chk_byte(d, 8'h00, "unmapped read");
    endtask
    // entry follows the pin in external mode, the automatic request otherwise
    task automatic test_entry;
        reg_write(ADDR_HOLDOVER_CTRL, 8'h02);
        hold_pin = 1'b1;
        @(negedge sys_clk);
        chk_bit(holdover_entry_request, 1'b1, "pin entry");
        hold_pin = 1'b0;
        auto_holdover_request = 1'b1;
        @(negedge sys_clk);
        chk_bit(holdover_entry_request, 1'b0, "auto ignored");
        reg_write(ADDR_HOLDOVER_CTRL, 8'h00);
        @(negedge sys_clk);
        chk_bit(holdover_entry_request, 1'b1, "auto entry");
        hold_pin = 1'b1;
        auto_holdover_request = 1'b0;
        @(negedge sys_clk);
        chk_bit(holdover_entry_request, 1'b0, "pin ignored");
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        test_reset();
        test_controls();
        test_status();
        test_freeze();
        test_entry();
        end_sim();
    end
    // whole run is under 70 cycles; this leaves wide margin
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end
endmodule // test_pll_status_holdover_regs
